/* hw/omcs_pkg.sv */
package omcs_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register map
	localparam int OMCS_ADDR_W = 2;
	localparam logic [1:0] OMCS_OFS_CONTROL = 2'h0;
	localparam logic [1:0] OMCS_OFS_TUNING = 2'h1;

	////////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int OMCS_IDLE_BIT = 7;
	localparam int OMCS_IFREQ_LSB = 4;
	localparam int OMCS_STARTUP_BIT = 3;
	localparam int OMCS_STABLE_BIT = 2;
	localparam int OMCS_SRC_LSB = 0;
	localparam int OMCS_LFSRC_BIT = 7;

	////////////////////////////////////////////////////////////////////////////////
	// values after reset
	localparam logic OMCS_IDLE_RST = 1'b0;
	localparam logic [2:0] OMCS_IFREQ_RST = 3'h4;
	localparam logic [1:0] OMCS_SRC_RST = 2'h0;
	localparam logic OMCS_LFSRC_RST = 1'b0;
	localparam logic OMCS_STARTUP_RST = 1'b0;
	localparam logic OMCS_STABLE_RST = 1'b0;

	////////////////////////////////////////////////////////////////////////////////
	// internal frequency codes
	localparam logic [2:0] OMCS_IFREQ_LOW = 3'h0;
	localparam logic [2:0] OMCS_IFREQ_DIRECT = 3'h7;

	////////////////////////////////////////////////////////////////////////////////
	// counts of oscillator edges, divider width
	localparam int OMCS_STARTUP_EDGES_DEF = 1024;
	localparam int OMCS_STABLE_EDGES_DEF = 16;
	localparam int OMCS_DIV_W = 8;

	////////////////////////////////////////////////////////////////////////////////
	// internal clock mux inputs: 0 slow osc, 1..7 by frequency code, 8 fast rc / 256
	localparam int OMCS_INT_SRCS = 9;
	localparam int OMCS_INT_SEL_W = 4;
	localparam logic [3:0] OMCS_INT_SEL_SLOW = 4'h0;
	localparam logic [3:0] OMCS_INT_SEL_DIV256 = 4'h8;

	// system clock mux inputs
	localparam int OMCS_SYS_SRCS = 3;
	localparam logic [1:0] OMCS_SYS_INTERNAL = 2'h0;
	localparam logic [1:0] OMCS_SYS_SECONDARY = 2'h1;
	localparam logic [1:0] OMCS_SYS_PRIMARY = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [1:0] {
		SRC_AUTO = 2'b00,
		SRC_SECONDARY = 2'b01,
		SRC_PRIMARY = 2'b10,
		SRC_INTERNAL = 2'b11
	} omcs_src_t;

	typedef enum logic [2:0] {
		MODE_FAST_RC_0 = 3'b000,
		MODE_FAST_RC_1 = 3'b001,
		MODE_FAST_RC_2 = 3'b010,
		MODE_FAST_RC_3 = 3'b011,
		FAST_CRYSTAL_MODE = 3'b100,
		FAST_CRYSTAL_MULTIPLIED_MODE = 3'b101,
		EXTERNAL_CLOCK_PLAIN_MODE = 3'b110,
		EXTERNAL_CLOCK_MULTIPLIED_MODE = 3'b111
	} omcs_mode_t;

	typedef enum logic [1:0] {
		SUT_INIT = 2'b00,
		SUT_COUNT = 2'b01,
		SUT_DONE = 2'b10
	} omcs_sut_t;

endpackage : omcs_pkg

/* hw/omcs_clk_mux.sv */
`timescale 1ns/10ps
module omcs_clk_mux #(
	parameter int N = 3,
	parameter int SEL_W = 2
) (
	input wire logic CLK, // core clock
	input wire logic RST, // synchronous reset, high
	input wire logic [N-1:0] SRC, // source clock levels
	input wire logic [SEL_W-1:0] SEL, // wanted source
	output logic CLK_OUT, // selected clock level
	output logic [SEL_W-1:0] CUR_SEL // source now followed
);

	////////////////////////////////////////////////////////////////////////////////
	// follow the current source; on a change finish the high phase of the old
	// source, hold low, and take the new one only while it is low
	always_ff @(posedge CLK) begin
		if (RST) begin
			CLK_OUT <= 1'b0;
			CUR_SEL <= '0;
		end else if (SEL != CUR_SEL) begin
			if (CLK_OUT) begin
				CLK_OUT <= SRC[CUR_SEL]; // RL15
			end else if (!SRC[SEL]) begin
				CUR_SEL <= SEL; // RL15
			end
		end else begin
			CLK_OUT <= SRC[CUR_SEL];
		end
	end

endmodule : omcs_clk_mux

/* hw/omcs_osc_ctl.sv */
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/10ps
// Operation
// RL1: six oscillator modes, crystal, external, internal
// RL2: five modes chosen by mode configuration
// RL3: software may select slow mode, default option
// RL4: source switches by software or automatically
// RL5: idle bit picks idle or sleep
// RL6: three-bit code selects internal frequency
// RL7: startup bit set when timer expires
// RL8: startup bit reset value follows two-speed config
// RL9: stable bit set when fast rc stable
// RL10: two-bit field selects system clock source
// RL11: frequency write switches internal clock immediately
// RL12: source write switches clock immediately
// RL13: low frequency source bit picks 31 kHz
// RL14: bit set gives fast rc over 256
// RL15: switching never makes a short pulse
module omcs_osc_ctl
	import omcs_pkg::*;
#(
	parameter int ADDR_W = omcs_pkg::OMCS_ADDR_W,
	parameter int STARTUP_EDGES = omcs_pkg::OMCS_STARTUP_EDGES_DEF,
	parameter int STABLE_EDGES = omcs_pkg::OMCS_STABLE_EDGES_DEF
) (
	input wire logic CORE_CLK, // core clock, 100 MHz
	input wire logic RST, // synchronous reset, high
	input wire logic [ADDR_W-1:0] ADDR, // register address
	input wire logic [7:0] WR_DATA, // write data
	input wire logic WR_EN, // write strobe
	input wire logic RD_EN, // read strobe
	output logic [7:0] RD_DATA, // read data, cycle after strobe
	input wire omcs_pkg::omcs_mode_t OSC_MODE_CFG, // oscillator mode configuration
	input wire logic TWO_SPEED_CFG, // two-speed start-up configuration
	input wire logic SLOW_DEFAULT_CFG, // start on slow internal osc
	input wire logic PRIMARY_OSC, // primary oscillator level
	input wire logic SECONDARY_OSC, // secondary oscillator level
	input wire logic FAST_RC_OSC, // fast internal rc level
	input wire logic SLOW_OSC, // slow internal oscillator level
	input wire logic SLEEP_REQ, // sleep instruction pulse
	output logic SYS_CLK, // device clock
	output logic [1:0] CLK_SOURCE, // source now driving the clock
	output logic IDLE_SELECT, // idle-on-sleep setting
	output logic SLEEP_ENTER, // pulse, full sleep entered
	output logic IDLE_ENTER, // pulse, idle entered
	output logic PRIMARY_READY, // start-up timeout status
	output logic INTERNAL_STABLE // fast rc stable
);

	////////////////////////////////////////////////////////////////////////////////
	// declarations
	localparam int SUT_W = $clog2(STARTUP_EDGES + 1);
	localparam int STB_W = $clog2(STABLE_EDGES + 1);
	localparam logic [SUT_W-1:0] SUT_LAST = SUT_W'(STARTUP_EDGES - 1);
	localparam logic [STB_W-1:0] STB_LAST = STB_W'(STABLE_EDGES - 1);

	logic idle_on_sleep_select;
	logic [2:0] internal_frequency_field;
	logic [1:0] system_clock_source_field;
	logic low_frequency_source_bit;
	logic startup_timeout_status;
	logic internal_freq_stable;
	logic init_pending;

	omcs_sut_t sut_state;
	logic [SUT_W-1:0] sut_count;
	logic [STB_W-1:0] stb_count;

	logic primary_prev;
	logic fast_prev;
	logic primary_rise;
	logic fast_rise;
	logic [OMCS_DIV_W-1:0] div_count;

	logic [OMCS_INT_SRCS-1:0] int_srcs;
	logic [OMCS_INT_SEL_W-1:0] int_sel;
	logic [OMCS_INT_SEL_W-1:0] next_int_sel;
	logic int_clk;

	logic [OMCS_SYS_SRCS-1:0] sys_srcs;
	logic [1:0] sys_sel;
	logic [1:0] next_sys_sel;
	logic [1:0] sys_cur;
	logic sys_clk_mux;
	logic mode_external;

	logic wr_control;
	logic wr_tuning;
	logic [7:0] control_value;

	////////////////////////////////////////////////////////////////////////////////
	// bus decode
	assign wr_control = WR_EN && (ADDR == ADDR_W'(OMCS_OFS_CONTROL));
	assign wr_tuning = WR_EN && (ADDR == ADDR_W'(OMCS_OFS_TUNING));

	// modes 1xx take the primary clock, 0xx the internal block
	assign mode_external = OSC_MODE_CFG[2]; // RL1 RL2

	always_comb begin
		control_value = 8'h00;
		control_value[OMCS_IDLE_BIT] = idle_on_sleep_select;
		control_value[OMCS_IFREQ_LSB +: 3] = internal_frequency_field;
		control_value[OMCS_STARTUP_BIT] = startup_timeout_status;
		control_value[OMCS_STABLE_BIT] = internal_freq_stable;
		control_value[OMCS_SRC_LSB +: 2] = system_clock_source_field;
	end

	////////////////////////////////////////////////////////////////////////////////
	// first cycle after reset release applies configuration levels
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			init_pending <= 1'b1;
		end else begin
			init_pending <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// oscillator control register, writable fields
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			idle_on_sleep_select <= OMCS_IDLE_RST; // RL5
			internal_frequency_field <= OMCS_IFREQ_RST; // RL6
			system_clock_source_field <= OMCS_SRC_RST;
		end else if (wr_control) begin
			idle_on_sleep_select <= WR_DATA[OMCS_IDLE_BIT]; // RL5
			internal_frequency_field <= WR_DATA[OMCS_IFREQ_LSB +: 3]; // RL6 RL11
			system_clock_source_field <= WR_DATA[OMCS_SRC_LSB +: 2]; // RL10 RL12
		end else if (init_pending && SLOW_DEFAULT_CFG) begin
			// slow internal oscillator as default clock
			internal_frequency_field <= OMCS_IFREQ_LOW; // RL3
			system_clock_source_field <= SRC_INTERNAL; // RL3
		end
	end

	// tuning register, only the low frequency source bit is kept
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			low_frequency_source_bit <= OMCS_LFSRC_RST;
		end else if (wr_tuning) begin
			low_frequency_source_bit <= WR_DATA[OMCS_LFSRC_BIT]; // RL13
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read port, data stand one cycle only, unmapped reads zero
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			RD_DATA <= 8'h00;
		end else if (RD_EN) begin
			case (ADDR)
				ADDR_W'(OMCS_OFS_CONTROL): begin
					RD_DATA <= control_value; // RL7 RL9
				end
				ADDR_W'(OMCS_OFS_TUNING): begin
					RD_DATA <= {low_frequency_source_bit, 7'h00};
				end
				default: begin
					RD_DATA <= 8'h00;
				end
			endcase
		end else begin
			RD_DATA <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// edge detection of oscillator levels; reset loads the live levels so that a
	// source already high at release does not count as a false first edge
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			primary_prev <= PRIMARY_OSC;
			fast_prev <= FAST_RC_OSC;
		end else begin
			primary_prev <= PRIMARY_OSC;
			fast_prev <= FAST_RC_OSC;
		end
	end

	assign primary_rise = PRIMARY_OSC && !primary_prev;
	assign fast_rise = FAST_RC_OSC && !fast_prev;

	////////////////////////////////////////////////////////////////////////////////
	// start-up timer on primary oscillator edges
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			sut_state <= SUT_INIT;
			sut_count <= '0;
			startup_timeout_status <= OMCS_STARTUP_RST;
		end else begin
			case (sut_state)
				SUT_INIT: begin
					// without two-speed start the core waits, so status reads done
					startup_timeout_status <= !TWO_SPEED_CFG; // RL8
					sut_state <= SUT_COUNT;
				end
				SUT_COUNT: begin
					if (mode_external && primary_rise) begin
						if (sut_count == SUT_LAST) begin
							sut_state <= SUT_DONE;
							startup_timeout_status <= 1'b1; // RL7
						end else begin
							sut_count <= sut_count + 1'b1; // RL7
						end
					end
				end
				SUT_DONE: begin
					startup_timeout_status <= 1'b1; // RL7
				end
				default: begin
					sut_state <= SUT_INIT;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// fast rc stability count
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			stb_count <= '0;
			internal_freq_stable <= OMCS_STABLE_RST; // RL9
		end else if (fast_rise && !internal_freq_stable) begin
			if (stb_count == STB_LAST) begin
				internal_freq_stable <= 1'b1; // RL9
			end else begin
				stb_count <= stb_count + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// fast rc divider chain, bit k divides by 2 to the k+1
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			div_count <= '0;
		end else if (fast_rise) begin
			div_count <= div_count + 1'b1; // RL6 RL14
		end
	end

	// code n from 1 to 7 gives 8 MHz over 2 to the 7-n
	assign int_srcs[0] = SLOW_OSC; // RL14
	assign int_srcs[7] = FAST_RC_OSC; // RL6
	assign int_srcs[8] = div_count[OMCS_DIV_W-1]; // RL14
	genvar gi;
	generate
		for (gi = 1; gi < 7; gi++) begin : g_div_tap
			assign int_srcs[gi] = div_count[6-gi]; // RL6
		end
	endgenerate

	always_comb begin
		next_int_sel = {1'b0, internal_frequency_field}; // RL6
		if (internal_frequency_field == OMCS_IFREQ_LOW) begin
			if (low_frequency_source_bit) begin
				next_int_sel = OMCS_INT_SEL_DIV256; // RL13 RL14
			end else begin
				next_int_sel = OMCS_INT_SEL_SLOW; // RL13 RL14
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			int_sel <= {1'b0, OMCS_IFREQ_RST};
		end else begin
			int_sel <= next_int_sel; // RL11
		end
	end

	omcs_clk_mux #(
		.N(OMCS_INT_SRCS),
		.SEL_W(OMCS_INT_SEL_W)
	) u_int_mux (
		.CLK(CORE_CLK),
		.RST(RST),
		.SRC(int_srcs),
		.SEL(int_sel),
		.CLK_OUT(int_clk),
		.CUR_SEL()
	);

	////////////////////////////////////////////////////////////////////////////////
	// system clock source choice
	always_comb begin
		case (system_clock_source_field)
			SRC_INTERNAL: begin
				next_sys_sel = OMCS_SYS_INTERNAL; // RL10
			end
			SRC_PRIMARY: begin
				next_sys_sel = OMCS_SYS_PRIMARY; // RL10
			end
			SRC_SECONDARY: begin
				next_sys_sel = OMCS_SYS_SECONDARY; // RL10
			end
			SRC_AUTO: begin
				next_sys_sel = mode_external ? OMCS_SYS_PRIMARY : OMCS_SYS_INTERNAL; // RL10
			end
			default: begin
				next_sys_sel = OMCS_SYS_INTERNAL;
			end
		endcase
		// two-speed start runs on the internal block until the primary is ready
		if (next_sys_sel == OMCS_SYS_PRIMARY && TWO_SPEED_CFG && !startup_timeout_status) begin
			next_sys_sel = OMCS_SYS_INTERNAL; // RL4
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			sys_sel <= OMCS_SYS_INTERNAL;
		end else begin
			sys_sel <= next_sys_sel; // RL4 RL12
		end
	end

	assign sys_srcs[OMCS_SYS_INTERNAL] = int_clk;
	assign sys_srcs[OMCS_SYS_SECONDARY] = SECONDARY_OSC;
	assign sys_srcs[OMCS_SYS_PRIMARY] = PRIMARY_OSC;

	omcs_clk_mux #(
		.N(OMCS_SYS_SRCS),
		.SEL_W(2)
	) u_sys_mux (
		.CLK(CORE_CLK),
		.RST(RST),
		.SRC(sys_srcs),
		.SEL(sys_sel),
		.CLK_OUT(sys_clk_mux),
		.CUR_SEL(sys_cur)
	);

	assign SYS_CLK = sys_clk_mux; // RL15

	////////////////////////////////////////////////////////////////////////////////
	// status outputs
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			CLK_SOURCE <= OMCS_SYS_INTERNAL;
			PRIMARY_READY <= OMCS_STARTUP_RST;
			INTERNAL_STABLE <= OMCS_STABLE_RST;
			IDLE_SELECT <= OMCS_IDLE_RST;
		end else begin
			CLK_SOURCE <= sys_cur;
			PRIMARY_READY <= startup_timeout_status;
			INTERNAL_STABLE <= internal_freq_stable;
			IDLE_SELECT <= idle_on_sleep_select;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// sleep instruction dispatch
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			SLEEP_ENTER <= 1'b0;
			IDLE_ENTER <= 1'b0;
		end else begin
			SLEEP_ENTER <= SLEEP_REQ && !idle_on_sleep_select; // RL5
			IDLE_ENTER <= SLEEP_REQ && idle_on_sleep_select; // RL5
		end
	end

endmodule : omcs_osc_ctl

/* verif/omcs_osc_ctl_properties.sv */
`timescale 1ns/10ps
module omcs_osc_ctl_properties
	import omcs_pkg::*;
#(
	parameter int ADDR_W = omcs_pkg::OMCS_ADDR_W,
	parameter int STARTUP_EDGES = omcs_pkg::OMCS_STARTUP_EDGES_DEF,
	parameter int STABLE_EDGES = omcs_pkg::OMCS_STABLE_EDGES_DEF,
	parameter int MIN_PHASE = 1
) (
	input wire logic CORE_CLK, // clock
	input wire logic RST, // reset
	input wire logic [ADDR_W-1:0] ADDR, // address
	input wire logic [7:0] WR_DATA, // write data
	input wire logic WR_EN, // write strobe
	input wire logic RD_EN, // read strobe
	input wire logic [7:0] RD_DATA, // read data
	input wire omcs_pkg::omcs_mode_t OSC_MODE_CFG, // mode config
	input wire logic TWO_SPEED_CFG, // two-speed config
	input wire logic SLOW_DEFAULT_CFG, // slow default
	input wire logic PRIMARY_OSC, // primary level
	input wire logic SECONDARY_OSC, // secondary level
	input wire logic FAST_RC_OSC, // fast rc level
	input wire logic SLOW_OSC, // slow level
	input wire logic SLEEP_REQ, // sleep pulse
	input wire logic SYS_CLK, // device clock
	input wire logic [1:0] CLK_SOURCE, // followed source
	input wire logic IDLE_SELECT, // idle setting
	input wire logic SLEEP_ENTER, // sleep pulse
	input wire logic IDLE_ENTER, // idle pulse
	input wire logic PRIMARY_READY, // startup status
	input wire logic INTERNAL_STABLE // stable status
);
	logic [7:0] hi_cnt;
	// length of the running high phase of the device clock
	always_ff @(posedge CORE_CLK) begin
		if (RST || !SYS_CLK) hi_cnt <= 8'h00;
		else if (hi_cnt != 8'hff) hi_cnt <= hi_cnt + 8'h01;
	end
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	sequence ctl_read;
		RD_EN && ADDR == OMCS_OFS_CONTROL;
	endsequence
	sequence tun_read;
		RD_EN && ADDR == OMCS_OFS_TUNING;
	endsequence
	chk_read_zero: assert property (!$past(RD_EN) |-> RD_DATA == 8'h00)
		else $error("read data outside read cycle");
	chk_status_mirror: assert property (ctl_read |=> RD_DATA[3] == PRIMARY_READY
		&& RD_DATA[2] == INTERNAL_STABLE) else $error("status bits differ from outputs");
	chk_tuning_ro: assert property (tun_read |=> RD_DATA[6:0] == 7'h00)
		else $error("tuning low bits not zero");
	chk_unmapped_zero: assert property (RD_EN && ADDR > 1 |=> RD_DATA == 8'h00)
		else $error("unmapped read not zero");
	chk_idle_follow: assert property (WR_EN && ADDR == OMCS_OFS_CONTROL
		|=> ##1 IDLE_SELECT == ($past(WR_DATA, 2) >> 7)) else $error("idle setting wrong");
	chk_sleep_answer: assert property (SLEEP_REQ |=> SLEEP_ENTER != IDLE_ENTER)
		else $error("sleep request not answered once");
	chk_sleep_kind: assert property (SLEEP_ENTER || IDLE_ENTER |-> IDLE_ENTER == IDLE_SELECT)
		else $error("sleep kind wrong");
	chk_ready_sticky: assert property (PRIMARY_READY |=> PRIMARY_READY)
		else $error("startup status dropped");
	chk_stable_sticky: assert property (INTERNAL_STABLE |=> INTERNAL_STABLE)
		else $error("stable status dropped");
	chk_source_legal: assert property (CLK_SOURCE != 2'h3)
		else $error("illegal clock source");
	chk_switch_low: assert property ($changed(CLK_SOURCE) |-> !$past(SYS_CLK))
		else $error("source taken while clock high");
	chk_high_phase: assert property ($fell(SYS_CLK) |-> hi_cnt >= MIN_PHASE)
		else $error("short clock pulse");
endmodule : omcs_osc_ctl_properties

/* verif/omcs_osc_model.sv */
`timescale 1ns/10ps
module omcs_osc_model #(
	parameter int PRI_HALF = 3,
	parameter int SEC_HALF = 5,
	parameter int FRC_HALF = 8,
	parameter int SLW_HALF = 11
) (
	input wire logic clk, // core clock
	output logic [3:0] osc // primary, secondary, fast rc, slow
);
	localparam int HALF [4] = '{PRI_HALF, SEC_HALF, FRC_HALF, SLW_HALF};
	int cnt [4];
	initial begin
		osc = 4'h0;
		foreach (cnt[i]) cnt[i] = 0;
	end
	// free-running sources, each phase a whole number of core cycles
	always @(posedge clk) begin
		for (int i = 0; i < 4; i++) begin
			if (cnt[i] == HALF[i] - 1) begin
				cnt[i] <= 0;
				osc[i] <= !osc[i];
			end else begin
				cnt[i] <= cnt[i] + 1;
			end
		end
	end
endmodule : omcs_osc_model

/* verif/omcs_osc_ctl_test.sv */
`timescale 1ns/10ps
module omcs_osc_ctl_test;
	import omcs_pkg::*;
	logic clk, rst, wr_en, rd_en, sleep_req, two_speed, slow_def;
	logic sys_clk, idle_sel, sleep_ent, idle_ent, pri_rdy, int_stb;
	logic [1:0] addr, clk_source;
	logic [7:0] wr_data, rd_data;
	logic [3:0] osc;
	omcs_mode_t osc_mode;
	int errors, cmp_count;
	logic [1:0] src_exp [4] = '{2'h2, 2'h1, 2'h2, 2'h0};
	omcs_osc_model u_osc (.clk(clk), .osc(osc));
	omcs_osc_ctl #(.STARTUP_EDGES(4), .STABLE_EDGES(2)) dut (
		.CORE_CLK(clk), .RST(rst), .ADDR(addr), .WR_DATA(wr_data), .WR_EN(wr_en),
		.RD_EN(rd_en), .RD_DATA(rd_data), .OSC_MODE_CFG(osc_mode), .TWO_SPEED_CFG(two_speed),
		.SLOW_DEFAULT_CFG(slow_def), .PRIMARY_OSC(osc[0]), .SECONDARY_OSC(osc[1]),
		.FAST_RC_OSC(osc[2]), .SLOW_OSC(osc[3]), .SLEEP_REQ(sleep_req), .SYS_CLK(sys_clk),
		.CLK_SOURCE(clk_source), .IDLE_SELECT(idle_sel), .SLEEP_ENTER(sleep_ent),
		.IDLE_ENTER(idle_ent), .PRIMARY_READY(pri_rdy), .INTERNAL_STABLE(int_stb));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task close_out();
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out
	task cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp_byte
	task cmp_period(input int got, input int exp);
		cmp_count++;
		if (got != exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp_period
	task wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask : wr
	task rd_chk(input logic [1:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 cmp_byte(rd_data, exp);
	endtask : rd_chk
	task sleep_chk(input logic [1:0] exp);
		@(posedge clk);
		sleep_req <= 1'b1;
		@(posedge clk);
		sleep_req <= 1'b0;
		#1 cmp_byte({6'h00, idle_ent, sleep_ent}, {6'h00, exp});
	endtask : sleep_chk
	task src_chk(input logic [1:0] exp);
		for (int i = 0; i < 400 && clk_source !== exp; i++) @(posedge clk);
		#1 cmp_byte({6'h00, clk_source}, {6'h00, exp});
	endtask : src_chk
	task rise();
		for (int i = 0; i < 5000 && sys_clk !== 1'b0; i++) @(posedge clk);
		for (int i = 0; i < 5000 && sys_clk !== 1'b1; i++) @(posedge clk);
	endtask : rise
	// period of the device clock in core cycles, after it has settled
	task per_chk(input int exp);
		time t0;
		repeat (3) rise();
		t0 = $time;
		rise();
		cmp_period(int'(($time - t0) / 10), exp);
	endtask : per_chk
	initial begin
		#1000000;
		errors++;
		close_out();
	end
	initial begin
		rst = 1'b1;
		wr_en = 1'b0;
		rd_en = 1'b0;
		sleep_req = 1'b0;
		addr = 2'h0;
		wr_data = 8'h00;
		two_speed = 1'b1;
		slow_def = 1'b0;
		osc_mode = FAST_CRYSTAL_MODE;
		errors = 0;
		cmp_count = 0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rd_chk(2'h0, 8'h40);
		rd_chk(2'h1, 8'h00);
		repeat (100) @(posedge clk);
		rd_chk(2'h0, 8'h4c);
		src_chk(2'h2);
		wr(2'h0, 8'h80);
		rd_chk(2'h0, 8'h8c);
		sleep_chk(2'h2);
		wr(2'h0, 8'h00);
		sleep_chk(2'h1);
		for (int s = 3; s >= 0; s--) begin
			wr(2'h0, {6'h1c, s[1:0]});
			src_chk(src_exp[s]);
		end
		@(posedge clk);
		osc_mode <= MODE_FAST_RC_0;
		wr(2'h0, 8'h70);
		src_chk(2'h0);
		for (int f = 7; f > 0; f--) begin
			wr(2'h0, {1'b0, f[2:0], 4'h3});
			rd_chk(2'h0, {1'b0, f[2:0], 4'hf});
			per_chk(16 << (7 - f));
		end
		wr(2'h0, 8'h03);
		per_chk(22);
		wr(2'h1, 8'hff);
		rd_chk(2'h1, 8'h80);
		per_chk(4096);
		wr(2'h2, 8'hff);
		rd_chk(2'h2, 8'h00);
		rd_chk(2'h3, 8'h00);
		rd_chk(2'h0, 8'h0f);
		@(posedge clk);
		rst <= 1'b1;
		slow_def <= 1'b1;
		two_speed <= 1'b0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rd_chk(2'h0, 8'h0b);
		per_chk(22);
		close_out();
	end
endmodule : omcs_osc_ctl_test
bind omcs_osc_ctl omcs_osc_ctl_properties #(.ADDR_W(ADDR_W), .STARTUP_EDGES(STARTUP_EDGES),
	.STABLE_EDGES(STABLE_EDGES), .MIN_PHASE(3)) u_chk (
	.CORE_CLK(CORE_CLK), .RST(RST), .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_EN(WR_EN),
	.RD_EN(RD_EN), .RD_DATA(RD_DATA), .OSC_MODE_CFG(OSC_MODE_CFG),
	.TWO_SPEED_CFG(TWO_SPEED_CFG), .SLOW_DEFAULT_CFG(SLOW_DEFAULT_CFG),
	.PRIMARY_OSC(PRIMARY_OSC), .SECONDARY_OSC(SECONDARY_OSC), .FAST_RC_OSC(FAST_RC_OSC),
	.SLOW_OSC(SLOW_OSC), .SLEEP_REQ(SLEEP_REQ), .SYS_CLK(SYS_CLK), .CLK_SOURCE(CLK_SOURCE),
	.IDLE_SELECT(IDLE_SELECT), .SLEEP_ENTER(SLEEP_ENTER), .IDLE_ENTER(IDLE_ENTER),
	.PRIMARY_READY(PRIMARY_READY), .INTERNAL_STABLE(INTERNAL_STABLE));
